// File: logic/mpc_pkg.sv
// Shared types and constants for the port pin control block
`default_nettype none
package mpc_pkg;

  // ********************************************************
  // Port selection codes for the software write port
  // ********************************************************
  localparam logic [2:0] PORT_ONE   = 3'h1;
  localparam logic [2:0] PORT_TWO   = 3'h2;
  localparam logic [2:0] PORT_THREE = 3'h3;
  localparam logic [2:0] PORT_FOUR  = 3'h4;
  localparam logic [2:0] PORT_FIVE  = 3'h5;
  localparam logic [2:0] PORT_SIX   = 3'h6;
  localparam logic [2:0] PORT_SEVEN = 3'h7;

  // ********************************************************
  // Field positions of shared pins
  // ********************************************************
  localparam int DIV_BIT   = 3; // Divider output on port one
  localparam int IRQ5_BIT  = 0; // Interrupt 5 and stop release on port two
  localparam int OSCI_BIT  = 1; // Low frequency oscillator input
  localparam int OSCO_BIT  = 2; // Low frequency oscillator output
  localparam int EVENT_COUNT_GATE_BIT  = 0; // Event count gate
  localparam int EVENT_COUNT_IN_BIT  = 1; // Event count input
  localparam int RXD_BIT   = 2; // Serial receive
  localparam int TXD_BIT   = 3; // Serial transmit
  localparam int TMR3_BIT  = 4; // Timer three input
  localparam int TMR4_BIT  = 5; // Timer four input

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] LATCH_RST = 8'hFF; // Latches released high
  localparam logic [7:0] DIR_RST   = 8'h00; // Tri-state ports are inputs
  localparam logic [7:0] DRIVE_RST = 8'h00; // Port four is open drain
  localparam logic [7:0] SEG_RST   = 8'h00; // Segment drive off

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_NS      = 10;   // System clock period
  localparam int RST_OUT_NS  = 1000; // Least low time driven on reset pin
  localparam int RST_OUT_CYC = (RST_OUT_NS + CLK_NS - 1) / CLK_NS;

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic [7:0] port_seven_segment_shared;
    logic [7:0] port_six_segment_shared;
    logic [4:0] port_five_analog_shared;
    logic [7:0] port_four_selectable_drive;
    logic [2:0] port_three_high_current;
    logic [2:0] port_two;
    logic [7:0] port_one;
  } mpc_pins_t;

  typedef struct packed {
    logic       latch_we; // Write output latch
    logic       cfg_we;   // Write direction, drive type or segment select
    logic [2:0] port;     // Port code
    logic [7:0] data;     // Write data, low bits used on narrow ports
  } mpc_wr_t;

  typedef struct packed {
    logic       divider_out;
    logic       divider_en;
    logic       low_freq_osc_out;
    logic       low_freq_osc_en;
    logic [2:0] pulse_width_out; // Zero, one, two
    logic [2:0] prog_divider_out;
    logic [2:0] pwm_sel;         // One picks pulse width, zero divider
    logic [2:0] p3_alt_en;
    logic       txd;
    logic       txd_en;
    logic [7:0] segment_drive_six;
    logic [7:0] segment_drive_seven;
  } mpc_periph_out_t;

  typedef struct packed {
    logic       ext_irq_zero;
    logic       ext_irq_one;
    logic       ext_irq_two;
    logic       ext_irq_five;
    logic       stop_release;    // Pulse on falling edge of the shared pin
    logic       low_freq_osc_in;
    logic       timer_three_input;
    logic       timer_four_input;
    logic       event_count_in;
    logic       event_count_gate;
    logic       rxd;
    logic [4:0] analog_in;       // Digital view of the shared analog pins
  } mpc_periph_in_t;

endpackage : mpc_pkg
`default_nettype wire

// File: logic/mpc_pin_cell.sv
// Pin driver and input sampler for all 43 port pins
`default_nettype none
module mpc_pin_cell (
  input  wire logic             clk,     // System clock
  input  wire logic             rst,     // Synchronous reset
  input  wire mpc_pkg::mpc_pins_t val,   // Level wanted on each pin
  input  wire mpc_pkg::mpc_pins_t push,  // One drives both levels
  input  wire mpc_pkg::mpc_pins_t en,    // One lets the pin drive at all
  input  wire mpc_pkg::mpc_pins_t pin_in,  // Pin levels
  output logic          [42:0]  pin_out_v, // Pin output levels
  output logic          [42:0]  pin_oe_v,  // Pin output enables
  output mpc_pkg::mpc_pins_t    pin_smp    // Sampled pin levels
);

  typedef struct packed {
    mpc_pkg::mpc_pins_t smp;
  } mpc_cell_st_t;

  mpc_cell_st_t st_ff;
  mpc_cell_st_t nxt_st;

  // ********************************************************
  // Output drive per pin
  // ********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 43; gi++)
    begin : g_pin
      // Sink-only pins float when high so the board pulls them up
      assign pin_out_v[gi] = val[gi];
      assign pin_oe_v[gi]  = en[gi] & (push[gi] | ~val[gi]);
    end
  endgenerate

  // ********************************************************
  // Input sampling
  // ********************************************************
  // Next state
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.smp = pin_in;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pin_smp = st_ff.smp;

endmodule : mpc_pin_cell
`default_nettype wire

// File: logic/mpc_reset_pin.sv
// Bidirectional reset pin: external request in, internal causes out
`default_nettype none
module mpc_reset_pin (
  input  wire logic clk,          // System clock
  input  wire logic rst,          // Synchronous reset
  input  wire logic rst_pin_in_n, // Reset pin level, low asserts
  input  wire logic wdt_rst,      // Watchdog reset cause, pulse
  input  wire logic trap_rst,     // Address trap reset cause, pulse
  input  wire logic sysclk_rst,   // System clock reset cause, pulse
  output logic      rst_pin_out,  // Reset pin output level
  output logic      rst_pin_oe,   // Reset pin output enable
  output logic      ext_rst_req   // External reset seen on the pin
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       drive;
    logic       ext;
  } mpc_rp_st_t;

  mpc_rp_st_t st_ff;
  mpc_rp_st_t nxt_st;

  localparam logic [7:0] CNT_LOAD = 8'(mpc_pkg::RST_OUT_CYC);

  // ********************************************************
  // Drive stretcher and external detect
  // ********************************************************
  // Own drive is masked so it never reads back as an external request
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.ext = ~rst_pin_in_n & ~st_ff.drive;
    if (wdt_rst | trap_rst | sysclk_rst)                 // [R12]
    begin
      nxt_st.cnt   = CNT_LOAD;
      nxt_st.drive = 1'b1;
    end
    else if (st_ff.cnt != 8'h00)
    begin
      nxt_st.cnt   = st_ff.cnt - 8'h01;
      nxt_st.drive = (st_ff.cnt != 8'h01);
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = st_ff.drive;
  assign ext_rst_req = st_ff.ext;

  // ********************************************************
  // Checks
  // ********************************************************
  sequence s_cause;
    wdt_rst | trap_rst | sysclk_rst;
  endsequence

  AST_RST_DRIVE_HOLD: assert property (@(posedge clk) disable iff (rst) // [R12]
    s_cause |=> rst_pin_oe [*8])
    else $error("reset pin not driven after internal cause");

  AST_RST_DRIVE_ENDS: assert property (@(posedge clk) disable iff (rst) // [R12]
    $fell(rst_pin_oe) |-> $past(st_ff.cnt) == 8'h01)
    else $error("reset pin released early");

endmodule : mpc_reset_pin
`default_nettype wire

// File: logic/mpc_port_ctrl.sv
// Port pin control: seven ports, shared functions and the reset pin
// Summary of operation
// R1: Each bit of port one is set to input or output by software.
// R2: Reset forces every port one bit to input.
// R3: Software sets the divider pin latch to one before divider output use.
// R4: Port two is latched; software sets latch to one for input use.
// R5: Port three pins carry pulse width or divider output, gated by latch.
// R6: Each port four bit is open drain or push-pull by software.
// R7: Reset makes every port four bit open drain.
// R8: Software sets port four latch to one before input or peripheral use.
// R9: Each bit of port five is set to input or output by software.
// R10: Port six pin drives segment only when its select bit is one.
// R11: Port seven pin drives segment only when selected, else latched bit.
// R12: Reset pin takes external reset and drives low on internal causes.
// R13: Port two bit zero feeds interrupt five and stop release.
// R14: Reading an input pin returns the sampled pin, not the latch.
`default_nettype none
module mpc_port_ctrl (
  input  wire logic                    clk,          // System clock
  input  wire logic                    rst,          // Synchronous reset
  input  wire mpc_pkg::mpc_wr_t        wr,           // Software write port
  output mpc_pkg::mpc_pins_t           port_rd,      // Port read data
  input  wire mpc_pkg::mpc_periph_out_t periph_out,  // Peripheral outputs
  output mpc_pkg::mpc_periph_in_t      periph_in,    // Peripheral inputs
  input  wire mpc_pkg::mpc_pins_t      pin_in,       // Port pin levels
  output mpc_pkg::mpc_pins_t           pin_out,      // Port pin outputs
  output mpc_pkg::mpc_pins_t           pin_oe,       // Port pin enables
  input  wire logic                    rst_pin_in_n, // Reset pin level
  output logic                         rst_pin_out,  // Reset pin output
  output logic                         rst_pin_oe,   // Reset pin enable
  output logic                         ext_rst_req,  // External reset seen
  input  wire logic                    wdt_rst,      // Watchdog cause
  input  wire logic                    trap_rst,     // Address trap cause
  input  wire logic                    sysclk_rst    // Clock fault cause
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    mpc_pkg::mpc_pins_t latch;  // Output latches
    logic [7:0]         dir1;   // Port one direction, one is output
    logic [4:0]         dir5;   // Port five direction, one is output
    logic [7:0]         drive4; // Port four drive, one is push-pull
    logic [7:0]         seg6;   // Port six segment select
    logic [7:0]         seg7;   // Port seven segment select
    mpc_pkg::mpc_pins_t rd;     // Registered read data
    mpc_pkg::mpc_periph_in_t pin; // Registered peripheral inputs
  } mpc_st_t;

  mpc_st_t            st_ff;
  mpc_st_t            nxt_st;
  mpc_pkg::mpc_pins_t val;
  mpc_pkg::mpc_pins_t push;
  mpc_pkg::mpc_pins_t en;
  mpc_pkg::mpc_pins_t smp;
  logic      [42:0]   out_v;
  logic      [42:0]   oe_v;

  // Writes to one port code, used for latch and config alike
  function automatic logic hit(input logic we, input logic [2:0] port,
                               input logic [2:0] code);
    hit = we & (port == code);
  endfunction : hit

  // Latched bit gated by a peripheral output when that function is on
  function automatic logic gate(input logic lat, input logic fen,
                                input logic fval);
    gate = lat & (fen ? fval : 1'b1);
  endfunction : gate

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb
  begin
    nxt_st = st_ff;
    // Latch writes, narrow ports take the low bits
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_ONE))
      nxt_st.latch.port_one = wr.data;
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_TWO))
      nxt_st.latch.port_two = wr.data[2:0];                            // [R4]
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_THREE))
      nxt_st.latch.port_three_high_current = wr.data[2:0];             // [R5]
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_FOUR))
      nxt_st.latch.port_four_selectable_drive = wr.data;
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_FIVE))
      nxt_st.latch.port_five_analog_shared = wr.data[4:0];
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_SIX))
      nxt_st.latch.port_six_segment_shared = wr.data;
    if (hit(wr.latch_we, wr.port, mpc_pkg::PORT_SEVEN))
      nxt_st.latch.port_seven_segment_shared = wr.data;
    // Configuration writes; ports two and three have none
    if (hit(wr.cfg_we, wr.port, mpc_pkg::PORT_ONE))
      nxt_st.dir1 = wr.data;                                           // [R1]
    if (hit(wr.cfg_we, wr.port, mpc_pkg::PORT_FOUR))
      nxt_st.drive4 = wr.data;                                         // [R6]
    if (hit(wr.cfg_we, wr.port, mpc_pkg::PORT_FIVE))
      nxt_st.dir5 = wr.data[4:0];                                      // [R9]
    if (hit(wr.cfg_we, wr.port, mpc_pkg::PORT_SIX))
      nxt_st.seg6 = wr.data;                                           // [R10]
    if (hit(wr.cfg_we, wr.port, mpc_pkg::PORT_SEVEN))
      nxt_st.seg7 = wr.data;                                           // [R11]
    // Read data: tri-state outputs show the latch, all else the pin
    nxt_st.rd = smp;                                                   // [R14]
    nxt_st.rd.port_one = (st_ff.dir1 & st_ff.latch.port_one) |
                         (~st_ff.dir1 & smp.port_one);                 // [R14]
    nxt_st.rd.port_five_analog_shared =
      (st_ff.dir5 & st_ff.latch.port_five_analog_shared) |
      (~st_ff.dir5 & smp.port_five_analog_shared);                     // [R14]
    // Peripheral inputs straight from the sampled pins
    nxt_st.pin.ext_irq_zero      = smp.port_one[0];
    nxt_st.pin.ext_irq_one       = smp.port_one[1];
    nxt_st.pin.ext_irq_two       = smp.port_one[2];
    nxt_st.pin.ext_irq_five      = smp.port_two[mpc_pkg::IRQ5_BIT];    // [R13]
    nxt_st.pin.stop_release      = st_ff.pin.ext_irq_five &
                                   ~smp.port_two[mpc_pkg::IRQ5_BIT];   // [R13]
    nxt_st.pin.low_freq_osc_in   = smp.port_two[mpc_pkg::OSCI_BIT];
    nxt_st.pin.event_count_gate  = smp.port_four_selectable_drive[mpc_pkg::EVENT_COUNT_GATE_BIT];
    nxt_st.pin.event_count_in    = smp.port_four_selectable_drive[mpc_pkg::EVENT_COUNT_IN_BIT];
    nxt_st.pin.rxd               = smp.port_four_selectable_drive[mpc_pkg::RXD_BIT];
    nxt_st.pin.timer_three_input = smp.port_four_selectable_drive[mpc_pkg::TMR3_BIT];
    nxt_st.pin.timer_four_input  = smp.port_four_selectable_drive[mpc_pkg::TMR4_BIT];
    nxt_st.pin.analog_in         = smp.port_five_analog_shared;
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset sets every latch high so latched pins come up released
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff        <= '0;
      st_ff.latch  <= {mpc_pkg::LATCH_RST, mpc_pkg::LATCH_RST,
                       mpc_pkg::LATCH_RST[4:0], mpc_pkg::LATCH_RST,
                       mpc_pkg::LATCH_RST[2:0], mpc_pkg::LATCH_RST[2:0],
                       mpc_pkg::LATCH_RST};
      st_ff.dir1   <= mpc_pkg::DIR_RST;                                // [R2]
      st_ff.dir5   <= mpc_pkg::DIR_RST[4:0];
      st_ff.drive4 <= mpc_pkg::DRIVE_RST;                              // [R7]
      st_ff.seg6   <= mpc_pkg::SEG_RST;
      st_ff.seg7   <= mpc_pkg::SEG_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // ********************************************************
  // Pin values, drive type and enable per port
  // ********************************************************
  // Shared outputs on ports one to four are ANDed with the latch, which is why a one is needed
  always_comb
  begin
    val  = st_ff.latch;
    push = '0;
    en   = '1;
    // Port one: tri-state, divider on one bit
    val.port_one[mpc_pkg::DIV_BIT] = gate(st_ff.latch.port_one[mpc_pkg::DIV_BIT],
                                          periph_out.divider_en,
                                          periph_out.divider_out);     // [R3]
    push.port_one = 8'hFF;
    en.port_one   = st_ff.dir1;                                        // [R1]
    // Port two: sink-only latched, oscillator out on one bit
    val.port_two[mpc_pkg::OSCO_BIT] = gate(st_ff.latch.port_two[mpc_pkg::OSCO_BIT],
                                           periph_out.low_freq_osc_en,
                                           periph_out.low_freq_osc_out); // [R4]
    // Port three: high current sink, pulse width or divider per pin
    for (int i = 0; i < 3; i++)
      val.port_three_high_current[i] =
        gate(st_ff.latch.port_three_high_current[i], periph_out.p3_alt_en[i],
             periph_out.pwm_sel[i] ? periph_out.pulse_width_out[i]
                                   : periph_out.prog_divider_out[i]); // [R5]
    // Port four: drive type per bit, serial transmit on one bit
    val.port_four_selectable_drive[mpc_pkg::TXD_BIT] =
      gate(st_ff.latch.port_four_selectable_drive[mpc_pkg::TXD_BIT],
           periph_out.txd_en, periph_out.txd);                         // [R8]
    push.port_four_selectable_drive = st_ff.drive4;                    // [R6]
    // Port five: tri-state, analog side is outside this block
    push.port_five_analog_shared = 5'h1F;
    en.port_five_analog_shared   = st_ff.dir5;                         // [R9]
    // Ports six and seven: segment drive replaces the latch when selected
    val.port_six_segment_shared = (st_ff.seg6 & periph_out.segment_drive_six) |
                                  (~st_ff.seg6 & st_ff.latch.port_six_segment_shared);
    push.port_six_segment_shared = st_ff.seg6;                         // [R10]
    val.port_seven_segment_shared =
      (st_ff.seg7 & periph_out.segment_drive_seven) |
      (~st_ff.seg7 & st_ff.latch.port_seven_segment_shared);
    push.port_seven_segment_shared = st_ff.seg7;                       // [R11]
  end

  // ********************************************************
  // Submodules
  // ********************************************************
  mpc_pin_cell u_cell (
    .clk       (clk),
    .rst       (rst),
    .val       (val),
    .push      (push),
    .en        (en),
    .pin_in    (pin_in),
    .pin_out_v (out_v),
    .pin_oe_v  (oe_v),
    .pin_smp   (smp)
  );

  mpc_reset_pin u_rst_pin (
    .clk          (clk),
    .rst          (rst),
    .rst_pin_in_n (rst_pin_in_n),
    .wdt_rst      (wdt_rst),
    .trap_rst     (trap_rst),
    .sysclk_rst   (sysclk_rst),
    .rst_pin_out  (rst_pin_out),
    .rst_pin_oe   (rst_pin_oe),
    .ext_rst_req  (ext_rst_req)
  );

  // Outputs
  assign pin_out   = out_v;
  assign pin_oe    = oe_v;
  assign port_rd   = st_ff.rd;
  assign periph_in = st_ff.pin;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_cfg(logic [2:0] code);
    wr.cfg_we && wr.port == code;
  endsequence

  sequence s_lat(logic [2:0] code);
    wr.latch_we && wr.port == code;
  endsequence

  AST_P1_INPUT_AFTER_RESET: assert property (disable iff (1'b0) // [R2]
    rst |=> pin_oe.port_one == 8'h00)
    else $error("port one not all inputs after reset");

  AST_P4_OPEN_DRAIN_RESET: assert property (disable iff (1'b0) // [R7]
    rst |=> pin_oe.port_four_selectable_drive == 8'h00)
    else $error("port four drives after reset");

  AST_P1_DIR_WRITE: assert property ( // [R1]
    s_cfg(mpc_pkg::PORT_ONE) |=> pin_oe.port_one == $past(wr.data))
    else $error("port one enables do not follow direction");

  AST_P5_DIR_WRITE: assert property ( // [R9]
    s_cfg(mpc_pkg::PORT_FIVE) |=> pin_oe.port_five_analog_shared == $past(wr.data[4:0]))
    else $error("port five enables do not follow direction");

  AST_P4_DRIVE_TYPE: assert property ( // [R6]
    s_cfg(mpc_pkg::PORT_FOUR) |=> pin_oe.port_four_selectable_drive ==
      ($past(wr.data) | ~pin_out.port_four_selectable_drive))
    else $error("port four drive type wrong");

  AST_P1_DIV_GATED: assert property ( // [R3]
    s_lat(mpc_pkg::PORT_ONE) ##0 !wr.data[mpc_pkg::DIV_BIT] |=>
      !pin_out.port_one[mpc_pkg::DIV_BIT])
    else $error("divider pin not held by latch");

  AST_P3_LATCH_GATED: assert property ( // [R5]
    s_lat(mpc_pkg::PORT_THREE) ##0 (wr.data[2:0] == 3'h0) |=>
      pin_out.port_three_high_current == 3'h0 && pin_oe.port_three_high_current == 3'h7)
    else $error("port three not pulled low by latch");

  AST_P2_RELEASE: assert property ( // [R4]
    s_lat(mpc_pkg::PORT_TWO) ##0 (wr.data[2:0] == 3'h7 && !periph_out.low_freq_osc_en) |=>
      pin_oe.port_two == 3'h0)
    else $error("port two not released for input");

  AST_P6_SEGMENT: assert property ( // [R10]
    s_cfg(mpc_pkg::PORT_SIX) |=> (((pin_out.port_six_segment_shared ^
      periph_out.segment_drive_six) & $past(wr.data)) == 8'h00) &&
      ((pin_oe.port_six_segment_shared & $past(wr.data)) == $past(wr.data)))
    else $error("port six segment not driven");

  AST_P7_SEGMENT: assert property ( // [R11]
    s_cfg(mpc_pkg::PORT_SEVEN) |=> (((pin_out.port_seven_segment_shared ^
      periph_out.segment_drive_seven) & $past(wr.data)) == 8'h00))
    else $error("port seven segment not driven");

  AST_P1_READ_PIN: assert property ( // [R14]
    (pin_oe.port_one == 8'h00) [*3] |-> port_rd.port_one == $past(pin_in.port_one, 2))
    else $error("port one input read not from pin");

  // The two pipeline stages still hold reset zeros just after release
  AST_IRQ5_PIN: assert property ( // [R13]
    !$past(rst) && !$past(rst, 2) |->
      periph_in.ext_irq_five == $past(pin_in.port_two[mpc_pkg::IRQ5_BIT], 2))
    else $error("interrupt five not from shared pin");

endmodule : mpc_port_ctrl
`default_nettype wire

// File: test/mpc_board.sv
// Board model: pull-ups and an outside driver on every pin
`default_nettype none
module mpc_board (
  input  wire mpc_pkg::mpc_pins_t out,   // Device levels
  input  wire mpc_pkg::mpc_pins_t oe,    // Device enables
  input  wire mpc_pkg::mpc_pins_t ext,   // Board levels
  input  wire mpc_pkg::mpc_pins_t ext_en, // Board drives
  output mpc_pkg::mpc_pins_t      lvl,   // Wire levels
  input  wire logic               r_out, // Reset pin level
  input  wire logic               r_oe,  // Reset pin enable
  input  wire logic               r_ext_n, // Board reset, low
  output logic                    r_lvl_n  // Reset wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device wins, then board; an idle wire floats up on its pull-up
  assign lvl = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en);
  assign r_lvl_n = r_oe ? r_out : r_ext_n; // Pulled-up reset wire
endmodule : mpc_board
`default_nettype wire

// File: test/test_mpc_port_ctrl.sv
// Random and corner tests of the port pin control block
`default_nettype none
module test_mpc_port_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, rext_n, rlvl_n, wdt, trap, sck, roe, rout, rreq;
  mpc_pkg::mpc_wr_t        wr;
  mpc_pkg::mpc_pins_t      rd, po, oe, ext, exten, lvl;
  mpc_pkg::mpc_periph_in_t pin, g;
  mpc_pkg::mpc_periph_out_t per;
  mpc_pkg::mpc_pins_t      e;
  int errors, n_checks, seed, i, k;
  logic [7:0] d, l;
  mpc_port_ctrl u_mpc_port_ctrl (.clk(clk), .rst(rst), .wr(wr), .port_rd(rd),
    .periph_out(per), .periph_in(pin), .pin_in(lvl), .pin_out(po), .pin_oe(oe),
    .rst_pin_in_n(rlvl_n), .rst_pin_out(rout), .rst_pin_oe(roe),
    .ext_rst_req(rreq), .wdt_rst(wdt), .trap_rst(trap), .sysclk_rst(sck));
  mpc_board u_mpc_board (.out(po), .oe(oe), .ext(ext), .ext_en(exten), .lvl(lvl),
    .r_out(rout), .r_oe(roe), .r_ext_n(rext_n), .r_lvl_n(rlvl_n));
  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [42:0] g, input logic [42:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Strobe lasts one cycle; the idle cycle after it lets the registered read data catch up
  task automatic w(input logic lw, input logic cw, input logic [2:0] p, input logic [7:0] dt);
    wr = {lw, cw, p, dt};
    step();
    wr = '0;
    step();
  endtask : w
  task automatic cfg_all(input logic [7:0] lt, input logic [7:0] cf);
    for (int p = 1; p < 8; p++)
    begin
      w(1'b1, 1'b0, 3'(p), lt);
      w(1'b0, 1'b1, 3'(p), cf);
    end
  endtask : cfg_all
  // Pin levels with every latch high and every direction, drive and segment bit set
  function automatic mpc_pkg::mpc_pins_t exp_out(input mpc_pkg::mpc_periph_out_t q);
    exp_out = '1;
    exp_out.port_one[mpc_pkg::DIV_BIT] = q.divider_out | ~q.divider_en;
    exp_out.port_two[mpc_pkg::OSCO_BIT] = q.low_freq_osc_out | ~q.low_freq_osc_en;
    exp_out.port_three_high_current = ((q.pwm_sel & q.pulse_width_out) |
      (~q.pwm_sel & q.prog_divider_out)) | ~q.p3_alt_en;
    exp_out.port_four_selectable_drive[mpc_pkg::TXD_BIT] = q.txd | ~q.txd_en;
    exp_out.port_six_segment_shared = q.segment_drive_six;
    exp_out.port_seven_segment_shared = q.segment_drive_seven;
  endfunction : exp_out
  // Peripheral inputs seen from pin levels, stop release left at zero
  function automatic mpc_pkg::mpc_periph_in_t exp_in(input mpc_pkg::mpc_pins_t x);
    exp_in = '0;
    exp_in.ext_irq_zero = x.port_one[0];
    exp_in.ext_irq_one = x.port_one[1];
    exp_in.ext_irq_two = x.port_one[2];
    exp_in.ext_irq_five = x.port_two[mpc_pkg::IRQ5_BIT];
    exp_in.low_freq_osc_in = x.port_two[mpc_pkg::OSCI_BIT];
    exp_in.timer_three_input = x.port_four_selectable_drive[mpc_pkg::TMR3_BIT];
    exp_in.timer_four_input = x.port_four_selectable_drive[mpc_pkg::TMR4_BIT];
    exp_in.event_count_in = x.port_four_selectable_drive[mpc_pkg::EVENT_COUNT_IN_BIT];
    exp_in.event_count_gate = x.port_four_selectable_drive[mpc_pkg::EVENT_COUNT_GATE_BIT];
    exp_in.rxd = x.port_four_selectable_drive[mpc_pkg::RXD_BIT];
    exp_in.analog_in = x.port_five_analog_shared;
  endfunction : exp_in
  task automatic test_done;
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // Hang guard, far beyond the expected run
  initial
  begin
    #200000;
    errors++;
    test_done();
  end
  initial
  begin
    seed = 86;
    errors = 0;
    n_checks = 0;
    rst = 1'b1;
    wr = '0;
    per = '0;
    {wdt, trap, sck} = 3'h0;
    rext_n = 1'b1;
    ext = '0;
    exten = '0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk(oe, '0);
    // Corners first, then random latch and config values
    for (i = 0; i < 10; i++)
    begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      l = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      cfg_all(l, d);
      chk(oe.port_one, d);
      chk(po.port_one & d, l & d);
      chk(rd.port_one & d, l & d);
      chk(oe.port_two, 3'(~l));
      chk(oe.port_three_high_current, 3'(~l));
      chk(oe.port_four_selectable_drive, 8'(d | ~l));
      chk(oe.port_five_analog_shared, 5'(d));
      chk(oe.port_six_segment_shared, 8'(d | ~l));
      chk(oe.port_seven_segment_shared, 8'(d | ~l));
    end
    // Shared functions: random peripheral outputs with all latches and config bits set
    cfg_all(8'hFF, 8'hFF);
    for (i = 0; i < 8; i++)
    begin
      per = 34'({$random(seed), $random(seed)});
      step();
      e = exp_out(per);
      chk(po, e);
      chk(oe.port_three_high_current, 3'(~e.port_three_high_current));
    end
    per = '0;
    // All pins as inputs: reads follow the board
    cfg_all(8'hFF, 8'h00);
    exten = '1;
    for (i = 0; i < 6; i++)
    begin
      ext = 43'({$random(seed), $random(seed)});
      repeat (3) step();
      chk(rd, ext);
      g = pin;
      g.stop_release = 1'b0;
      chk(g, exp_in(ext));
      chk(pin.ext_irq_five, ext.port_two[0]);
    end
    ext.port_two[0] = 1'b1;
    repeat (4) step();
    ext.port_two[0] = 1'b0;
    k = 0;
    repeat (5)
    begin
      step();
      if (pin.stop_release === 1'b1) k++;
    end
    chk(k, 1);
    // Each internal cause drives the reset pin low for its full span
    for (i = 0; i < 3; i++)
    begin
      {wdt, trap, sck} = 3'h4 >> i;
      step();
      {wdt, trap, sck} = 3'h0;
      chk({roe, rout, rreq}, 3'h4);
      repeat (98) step();
      chk(roe, 1'b1);
      repeat (5) step();
      chk(roe, 1'b0);
    end
    rext_n = 1'b0;
    repeat (2) step();
    chk(rreq, 1'b1);
    rext_n = 1'b1;
    test_done();
  end
endmodule : test_mpc_port_ctrl
`default_nettype wire
